// file: mem_glue_consts.vh
/*
 * Shared constants for the external memory glue: address map, sequencer
 * timing, baud byte location and baud code table.
 * Assumes inclusion by bare name from the design file and the bench.
 */
`ifndef MEM_GLUE_CONSTS_VH
`define MEM_GLUE_CONSTS_VH

// ---------------------------------------------------------------
// Address map
// ---------------------------------------------------------------
`define ADDR_W           16
`define SEL_BIT          15
`define INT_ROM_TOP      16'h07ff
`define BAUD_BYTE_ADDR   16'hfffd
`define RAM_ALIAS_MASK   16'h0fff

// ---------------------------------------------------------------
// Baud code in the low bits of the stored byte
// ---------------------------------------------------------------
`define BAUD_CODE_W      3
`define BAUD_110         3'h6
`define BAUD_150         3'h0
`define BAUD_300         3'h7
`define BAUD_1200        3'h5
`define BAUD_2400        3'h4
`define BAUD_4800        3'h3
`define BAUD_9600        3'h2
`define BAUD_19200       3'h1

// ---------------------------------------------------------------
// Timing of the internal bus sequencer, in clk cycles per phase
// ---------------------------------------------------------------
`define PHASE_NS         30
`define CLK_NS           10
`define PHASE_CYC        ((`PHASE_NS + `CLK_NS - 1) / `CLK_NS)
`define PHASE_CNT_W      4

// ---------------------------------------------------------------
// Divider reloads per baud code: prescale, then timer
// ---------------------------------------------------------------
// Approximate 16x rates from 100 MHz, not exact baud
`define DIV_PRE_110      6'd63
`define DIV_TIM_110      8'd255
`define DIV_PRE_150      6'd63
`define DIV_TIM_150      8'd255
`define DIV_PRE_300      6'd40
`define DIV_TIM_300      8'd255
`define DIV_PRE_1200     6'd20
`define DIV_TIM_1200     8'd255
`define DIV_PRE_2400     6'd10
`define DIV_TIM_2400     8'd255
`define DIV_PRE_4800     6'd5
`define DIV_TIM_4800     8'd255
`define DIV_PRE_9600     6'd2
`define DIV_TIM_9600     8'd216
`define DIV_PRE_19200    6'd1
`define DIV_TIM_19200    8'd162

// Serial uses two port-3 pins
`define P3_SIN_BIT       0
`define P3_SOUT_BIT      7

`endif

// file: mem_glue.v
/*
 * Device-side external bus engine with memory glue: drives a multiplexed
 * low address/data byte, the upper address byte, strobes, chip selects,
 * the EPROM latch enable, and fetches the baud code at reset.
 * Assumes memories keep their own bus manners (drive only in a read
 * data phase) and a 100 MHz clk.
 */
module mem_glue #(
    parameter PRESCALE_W = 6,
    parameter TIMER_W    = 8
) (
    input  wire                      clk,
    input  wire                      sys_rst,
    // Core request port
    input  wire                      req_valid,
    input  wire                      req_write,
    input  wire [15:0]               req_addr,
    input  wire [7:0]                req_wdata,
    output reg                       req_done,
    output reg  [7:0]                req_rdata,
    // Software override of the bit rate divider
    input  wire                      rate_load,
    input  wire [PRESCALE_W-1:0]     rate_prescale,
    input  wire [TIMER_W-1:0]        rate_count,
    // External bus pins
    output reg  [7:0]                muxed_addr_data_low_out,
    output reg                       muxed_addr_data_low_oe,
    input  wire [7:0]                muxed_addr_data_low_in,
    output reg  [7:0]                upper_address_byte,
    output reg                       address_strobe_n,
    output reg                       data_strobe_n,
    output reg                       read_not_write,
    output reg                       ram_cs_n,
    output reg                       rom_cs_n,
    output reg                       ram_address_clock,
    output reg                       latch_enable,
    // Serial pins on port 3
    input  wire                      serial_in,
    output reg                       serial_out,
    output reg                       baud_tick,
    output reg  [2:0]                baud_code,
    output reg                       baud_ready,
    input  wire [5:0]                user_p3_in,
    output reg  [5:0]                user_p3_sync
);
`include "mem_glue_consts.vh"

// ---------------------------------------------------------------
// Bus sequencer states
// ---------------------------------------------------------------
localparam S_IDLE = 5'h01;
localparam S_ADDR = 5'h02;
localparam S_LAT  = 5'h04;
localparam S_DATA = 5'h08;
localparam S_END  = 5'h10;

reg  [4:0]              state;
reg  [`PHASE_CNT_W-1:0] phase;
reg                     cur_write;
reg  [15:0]             cur_addr;
reg  [7:0]              cur_wdata;
reg                     cur_fetch;
reg                     fetch_pending;
reg  [7:0]              din_s1;
reg  [7:0]              din_s2;
reg                     sin_s1;
reg                     sin_s2;
reg  [5:0]              user_s1;
reg  [PRESCALE_W-1:0]   pre_reload;
reg  [TIMER_W-1:0]      tim_reload;
reg  [PRESCALE_W-1:0]   pre_cnt;
reg  [TIMER_W-1:0]      tim_cnt;
wire                    phase_done;
wire                    is_external;
wire                    sel_rom;
wire                    fetch_last;
reg  [PRESCALE_W-1:0]   next_pre;
reg  [TIMER_W-1:0]      next_tim;

assign phase_done  = (phase == `PHASE_CYC - 1);
assign is_external = (cur_addr > `INT_ROM_TOP);
assign sel_rom     = cur_addr[`SEL_BIT];
assign fetch_last  = (state == S_DATA) && cur_fetch && (phase == `PHASE_CYC + 1);

// ---------------------------------------------------------------
// Pin synchronisers
// ---------------------------------------------------------------
// Two stages before anything reads outside levels
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        din_s1       <= 8'h00;
        din_s2       <= 8'h00;
        sin_s1       <= 1'b1;
        sin_s2       <= 1'b1;
        user_s1      <= 6'h00;
        user_p3_sync <= 6'h00;
    end else begin
        din_s1       <= muxed_addr_data_low_in;
        din_s2       <= din_s1;
        sin_s1       <= serial_in;
        sin_s2       <= sin_s1;
        user_s1      <= user_p3_in;
        user_p3_sync <= user_s1;
    end
end

// ---------------------------------------------------------------
// Bus sequencer
// ---------------------------------------------------------------
// Fetch of the baud byte takes priority over core requests
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        state                   <= S_IDLE;
        phase                   <= {`PHASE_CNT_W{1'b0}};
        cur_write               <= 1'b0;
        cur_addr                <= 16'h0000;
        cur_wdata               <= 8'h00;
        cur_fetch               <= 1'b0;
        fetch_pending           <= 1'b1;
        req_done                <= 1'b0;
        req_rdata               <= 8'h00;
        muxed_addr_data_low_out <= 8'h00;
        muxed_addr_data_low_oe  <= 1'b0;
        upper_address_byte      <= 8'h00;
        address_strobe_n        <= 1'b1;
        data_strobe_n           <= 1'b1;
        read_not_write          <= 1'b1;
        ram_cs_n                <= 1'b1;
        rom_cs_n                <= 1'b1;
        ram_address_clock       <= 1'b1;
        latch_enable            <= 1'b0;
        baud_code               <= `BAUD_150;
        baud_ready              <= 1'b0;
    end else begin
        req_done <= 1'b0;
        case (state)
            S_IDLE: begin
                phase <= {`PHASE_CNT_W{1'b0}};
                if (fetch_pending) begin
                    cur_fetch <= 1'b1;
                    cur_write <= 1'b0;
                    cur_addr  <= `BAUD_BYTE_ADDR;
                    state     <= S_ADDR;
                end else if (req_valid) begin
                    cur_fetch <= 1'b0;
                    cur_write <= req_write;
                    cur_addr  <= req_addr;
                    cur_wdata <= req_wdata;
                    state     <= S_ADDR;
                end
            end
            S_ADDR: begin
                // Address out on both ports, strobe low
                muxed_addr_data_low_out <= cur_addr[7:0];
                muxed_addr_data_low_oe  <= 1'b1;
                upper_address_byte      <= cur_addr[15:8];
                read_not_write          <= ~cur_write;
                ram_cs_n  <= ~(is_external & ~sel_rom);
                rom_cs_n  <= ~(is_external & sel_rom);
                address_strobe_n  <= 1'b0;
                ram_address_clock <= 1'b0;
                latch_enable      <= 1'b1;
                state             <= S_LAT;
            end
            S_LAT: begin
                phase <= phase + 1'b1;
                if (phase_done) begin
                    // Rising strobe closes the latch and clocks RAM address
                    address_strobe_n  <= 1'b1;
                    ram_address_clock <= 1'b1;
                    latch_enable      <= 1'b0;
                    phase             <= {`PHASE_CNT_W{1'b0}};
                    muxed_addr_data_low_out <= cur_wdata;
                    muxed_addr_data_low_oe  <= cur_write;
                    state <= S_DATA;
                end
            end
            S_DATA: begin
                data_strobe_n <= 1'b0;
                phase         <= phase + 1'b1;
                // Extra cycles cover the two-stage input delay
                if (phase == `PHASE_CYC + 1) begin
                    data_strobe_n <= 1'b1;
                    phase         <= {`PHASE_CNT_W{1'b0}};
                    state         <= S_END;
                    if (cur_fetch) begin
                        baud_code     <= din_s2[`BAUD_CODE_W-1:0];
                        baud_ready    <= 1'b1;
                        fetch_pending <= 1'b0;
                    end else begin
                        req_rdata <= din_s2;
                        req_done  <= 1'b1;
                    end
                end
            end
            S_END: begin
                muxed_addr_data_low_oe <= 1'b0;
                read_not_write         <= 1'b1;
                ram_cs_n               <= 1'b1;
                rom_cs_n               <= 1'b1;
                state                  <= S_IDLE;
            end
            default: state <= S_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// Baud code to divider reload
// ---------------------------------------------------------------
// Decoded from the arriving byte, so the reload is ready as the timer starts
always @* begin
    next_pre = {PRESCALE_W{1'b1}};
    next_tim = {TIMER_W{1'b1}};
    case (din_s2[`BAUD_CODE_W-1:0])
        `BAUD_110:   begin next_pre = `DIV_PRE_110;   next_tim = `DIV_TIM_110;   end
        `BAUD_150:   begin next_pre = `DIV_PRE_150;   next_tim = `DIV_TIM_150;   end
        `BAUD_300:   begin next_pre = `DIV_PRE_300;   next_tim = `DIV_TIM_300;   end
        `BAUD_1200:  begin next_pre = `DIV_PRE_1200;  next_tim = `DIV_TIM_1200;  end
        `BAUD_2400:  begin next_pre = `DIV_PRE_2400;  next_tim = `DIV_TIM_2400;  end
        `BAUD_4800:  begin next_pre = `DIV_PRE_4800;  next_tim = `DIV_TIM_4800;  end
        `BAUD_9600:  begin next_pre = `DIV_PRE_9600;  next_tim = `DIV_TIM_9600;  end
        `BAUD_19200: begin next_pre = `DIV_PRE_19200; next_tim = `DIV_TIM_19200; end
        default:     begin next_pre = `DIV_PRE_150;   next_tim = `DIV_TIM_150;   end
    endcase
end

// ---------------------------------------------------------------
// Bit rate timer with prescaler
// ---------------------------------------------------------------
// Reload follows the fetched code until software loads its own
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        pre_reload <= {PRESCALE_W{1'b1}};
        tim_reload <= {TIMER_W{1'b1}};
        pre_cnt    <= {PRESCALE_W{1'b0}};
        tim_cnt    <= {TIMER_W{1'b0}};
        baud_tick  <= 1'b0;
    end else begin
        baud_tick <= 1'b0;
        if (rate_load) begin
            pre_reload <= rate_prescale;
            tim_reload <= rate_count;
        end else if (fetch_last) begin
            pre_reload <= next_pre;
            tim_reload <= next_tim;
        end
        if (baud_ready) begin
            if (pre_cnt == {PRESCALE_W{1'b0}}) begin
                pre_cnt <= pre_reload;
                if (tim_cnt == {TIMER_W{1'b0}}) begin
                    tim_cnt   <= tim_reload;
                    baud_tick <= 1'b1;
                end else begin
                    tim_cnt <= tim_cnt - 1'b1;
                end
            end else begin
                pre_cnt <= pre_cnt - 1'b1;
            end
        end
    end
end

// ---------------------------------------------------------------
// Serial pin
// ---------------------------------------------------------------
// Only data in and out; no modem handshakes exist here
always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
        serial_out <= 1'b1;
    end else begin
        serial_out <= sin_s2;
    end
end

endmodule

// file: mem_glue_asserts.sv
/* Concurrent checks on the external bus pins of mem_glue.
   Assumes a single clk domain and an async active-high sys_rst. */
module mem_glue_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [15:0] req_addr,
    input wire logic [7:0]  req_wdata,
    input wire logic        req_done,
    input wire logic [7:0]  muxed_addr_data_low_out,
    input wire logic        muxed_addr_data_low_oe,
    input wire logic [7:0]  upper_address_byte,
    input wire logic        address_strobe_n,
    input wire logic        data_strobe_n,
    input wire logic        read_not_write,
    input wire logic        ram_cs_n,
    input wire logic        rom_cs_n,
    input wire logic        ram_address_clock,
    input wire logic        latch_enable,
    input wire logic        baud_ready
);
    // ----------------------------------------
    // Pin relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic [15:0] bus_addr = {upper_address_byte, muxed_addr_data_low_out};
    wire logic        any_cs   = !ram_cs_n || !rom_cs_n;

    ram_clock_copy_a: assert property (ram_address_clock == address_strobe_n)
        else $error("ram address clock differs from address strobe");
    latch_inverse_a: assert property (latch_enable == !address_strobe_n)
        else $error("latch enable is not the inverted address strobe");
    addr_drive_a: assert property ($fell(address_strobe_n) && baud_ready |->
        muxed_addr_data_low_oe && bus_addr == req_addr)
        else $error("address phase does not carry the request address");
    fetch_addr_a: assert property ($fell(address_strobe_n) && !baud_ready |->
        bus_addr == 16'hfffd) else $error("first fetch is not at fffd");
    read_release_a: assert property (!data_strobe_n && read_not_write |->
        !muxed_addr_data_low_oe) else $error("device drives bus in read data phase");
    write_data_a: assert property (!data_strobe_n && !read_not_write |->
        muxed_addr_data_low_oe && muxed_addr_data_low_out == req_wdata)
        else $error("write data missing during data strobe");
    done_time_a: assert property ($fell(address_strobe_n) && baud_ready |->
        ##[8:11] req_done) else $error("access did not complete in time");
    ds_width_a: assert property ($fell(data_strobe_n) |->
        (!data_strobe_n && address_strobe_n)[*4]) else $error("data strobe too short");
    cs_decode_a: assert property (any_cs |-> ram_cs_n != rom_cs_n &&
        rom_cs_n == !upper_address_byte[7]) else $error("chip select not from bit 15");
    int_rom_quiet_a: assert property (any_cs |-> upper_address_byte >= 8'h08)
        else $error("chip select in internal rom range");
    cs_active_a: assert property ($fell(address_strobe_n) && upper_address_byte >= 8'h08
        |-> any_cs) else $error("external access without chip select");

    // Main traffic kinds seen at least once
    cover property (!ram_cs_n && !data_strobe_n && !read_not_write);
    cover property (!rom_cs_n && !data_strobe_n && read_not_write);
    cover property ($fell(address_strobe_n) && !baud_ready);
endmodule

bind mem_glue mem_glue_asserts chk_u (.*);

// file: mem_glue_mem_model.sv
/* Behavioural far side: self-latching 4K RAM and 2K EPROM behind a latch.
   Assumes the bench merges its bus_level output onto the muxed input. */
module mem_glue_mem_model (
    input wire logic        clk,
    input wire logic        ram_cs_n,
    input wire logic        rom_cs_n,
    input wire logic        data_strobe_n,
    input wire logic        read_not_write,
    input wire logic        ram_address_clock,
    input wire logic        latch_enable,
    input wire logic [7:0]  upper_address_byte,
    input wire logic [7:0]  bus_out,
    input wire logic        bus_oe,
    input wire logic [7:0]  baud_byte,
    output logic [7:0]      bus_level
);
    // ----------------------------------------
    // Storage and address capture
    // ----------------------------------------
    logic [7:0]  ram [0:4095];
    logic [7:0]  rom [0:2047];
    logic [11:0] ram_a;
    logic [7:0]  rom_lo;
    logic [7:0]  last = 8'h00;
    wire  [10:0] rom_a   = {upper_address_byte[2:0], rom_lo};
    wire  [7:0]  rom_val = (rom_a == 11'h7fd) ? baud_byte : rom[rom_a];
    wire         rd      = !data_strobe_n && read_not_write;
    initial for (int i = 0; i < 2048; i++) rom[i] = i[7:0] ^ 8'h5a;
    // Only 12 address bits kept, so upper bits alias
    // Sampled on clk while the strobe is low: the bus turns at the strobe's rise
    always @(posedge clk) if (!ram_address_clock) ram_a <= {upper_address_byte[3:0], bus_out};
    always @(posedge clk) if (latch_enable) rom_lo <= bus_out;
    always @(posedge data_strobe_n) if (!ram_cs_n && !read_not_write) ram[ram_a] <= bus_out;
    // Released lines float: show a changing pattern, not a held value
    always @(posedge clk) last <= bus_level;
    always @* begin
        if (bus_oe) bus_level = bus_out;
        else if (rd && !ram_cs_n) bus_level = ram[ram_a];
        else if (rd && !rom_cs_n) bus_level = rom_val;
        else bus_level = ~last;
    end
endmodule

// file: mem_glue_bench.sv
/* Self-checking bench for mem_glue: baud fetch, RAM, EPROM, pins.
   Assumes mem_glue_mem_model as far side and the bound checker. */
`include "mem_glue_consts.vh"
module mem_glue_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, sys_rst = 1, req_valid = 0, req_write = 0, rate_load = 0, serial_in = 1;
    logic [15:0] req_addr = 16'h0000;
    logic [7:0]  req_wdata = 8'h00, baud_byte = 8'h00, rate_count = 8'h00, rdata;
    logic [5:0]  rate_prescale = 6'h00, user_p3_in = 6'h00;
    logic [1:0]  cs_seen;
    wire  [7:0]  muxed_addr_data_low_out, muxed_addr_data_low_in, req_rdata, upper_address_byte;
    wire  [5:0]  user_p3_sync;
    wire  [2:0]  baud_code;
    wire req_done, muxed_addr_data_low_oe, address_strobe_n, data_strobe_n, read_not_write;
    wire ram_cs_n, rom_cs_n, ram_address_clock, latch_enable, serial_out, baud_tick, baud_ready;
    int fails = 0, total_checks = 0, cycles = 0;

    mem_glue dut_u (.*);
    mem_glue_mem_model mem_u (.clk(clk), .ram_cs_n(ram_cs_n), .rom_cs_n(rom_cs_n),
        .data_strobe_n(data_strobe_n), .read_not_write(read_not_write),
        .ram_address_clock(ram_address_clock), .latch_enable(latch_enable),
        .upper_address_byte(upper_address_byte), .bus_out(muxed_addr_data_low_out),
        .bus_oe(muxed_addr_data_low_oe), .baud_byte(baud_byte),
        .bus_level(muxed_addr_data_low_in));

    // ----------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------
    initial forever #5 clk = ~clk;
    // Whole run needs somewhat over a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            final_report();
        end
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One core access; cs_seen records which chip selects went low
    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        cs_seen = 2'b00;
        do begin
            @(negedge clk);
            cs_seen |= {~ram_cs_n, ~rom_cs_n};
            n++;
        end while (req_done !== 1'b1 && n < 40);
        check(req_done, 1'b1);
        rdata = req_rdata;
        @(posedge clk);
        req_valid <= 0;
    endtask
    task automatic reset_fetch(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clk);
        sys_rst <= 1;
        baud_byte <= b;
        repeat (3) @(posedge clk);
        sys_rst <= 0;
        while (baud_ready !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        check(baud_ready, 1'b1);
        check(baud_code, b[2:0]);
    endtask
    // Waits for a rate tick, then counts cycles to the next one
    task automatic tick_gap(output int n);
        int w;
        w = 0;
        n = 0;
        while (baud_tick !== 1'b1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        do begin
            @(negedge clk);
            n++;
        end while (baud_tick !== 1'b1 && n < 2000);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Software rate change, then reset must bring back the stored code
    task automatic t_baud_codes();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            rate_prescale <= 6'h01;
            rate_count <= i[7:0] + 8'h02;
            rate_load <= 1;
            @(posedge clk);
            rate_load <= 0;
            reset_fetch({5'h15, i[2:0]});
        end
    endtask
    task automatic t_ram();
        logic [15:0] al [3] = '{16'h18ff, 16'h28ff, 16'h78ff};
        access(1, 16'h08ff, 8'ha5);
        check(cs_seen, 2'b10);
        access(1, 16'h0fff, 8'h3c);
        foreach (al[k]) begin
            access(0, al[k], 8'h00);
            check(rdata, 8'ha5);
            check(cs_seen, 2'b10);
        end
        access(0, 16'h7fff, 8'h00);
        check(rdata, 8'h3c);
    endtask
    task automatic t_rom();
        access(0, 16'hfffd, 8'h00);
        check(rdata, baud_byte);
        check(cs_seen, 2'b01);
        access(0, 16'h8000, 8'h00);
        check(rdata, 8'h5a);
        access(0, 16'h8801, 8'h00);
        check(rdata, 8'h5b);
    endtask
    task automatic t_int_rom();
        access(0, 16'h07ff, 8'h00);
        check(cs_seen, 2'b00);
        access(1, 16'h0000, 8'h77);
        check(cs_seen, 2'b00);
    endtask
    task automatic t_pins();
        @(posedge clk);
        user_p3_in <= 6'h2b;
        serial_in <= 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check(user_p3_sync, 6'h2b);
        check(serial_out, 1'b0);
    endtask
    // Software rate, then reset must fall back to the stored code's rate
    task automatic t_rate();
        int n;
        @(posedge clk);
        rate_prescale <= 6'h01;
        rate_count <= 8'h03;
        rate_load <= 1;
        @(posedge clk);
        rate_load <= 0;
        repeat (2) tick_gap(n);
        check(n, 16'd8);
        reset_fetch(8'h01);
        tick_gap(n);
        check(n, (`DIV_PRE_19200 + 1) * (`DIV_TIM_19200 + 1));
    endtask

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        t_baud_codes();
        t_ram();
        t_rom();
        t_int_rom();
        t_pins();
        t_rate();
        final_report();
    end
endmodule
